/* hdl/hstc_core.v */
/*
  high speed timer/counter core: 10-bit counter, prescaler, four compare
  channels (one is TOP), flags and masks, AHB-Lite register slave.
  assumes one slave on the bus (hreadyout is the bus hready) and that the
  fast peripheral clock arrives as a pin sampled on hclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hstc_regs.vh"

module hstc_core (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // pins from outside the clock domain
  input wire fast_clock_pin,
  input wire pll_lock_pin,
  input wire fault_pin,
  // interrupt request and acknowledge per source
  input wire [4:0] int_ack,
  output wire [4:0] int_req,
  // compare outputs
  output reg compare_pin_a,
  output reg compare_pin_b,
  output reg compare_pin_d
);

  // ==========================================================
  // bus side registers
  reg wr_pend_r; // write data phase in progress
  reg [5:0] wr_addr_r; // latched write offset
  reg [1:0] shared_high_bits_r; // shared upper bits buffer
  reg [9:0] buf_r [0:3]; // latest written compare values a,b,top,d
  reg [7:0] control_a_r; // pwm enables a,b,d in bits 2:0
  reg [7:0] control_b_r; // clock_select in bits 3:0
  reg [7:0] control_c_r; // compare_output_mode a,b,d
  reg [7:0] control_d_r; // waveform_mode 1:0, fault enable bit 7
  reg [7:0] interrupt_mask_r; // mask of ovf,a,b,d
  reg [7:0] pll_control_status_r; // fast clock enable, low speed select
  reg [4:0] interrupt_flags_r; // sticky flags
  reg cnt_wr_r; // count write strobe
  reg [9:0] cnt_wdat_r; // count write data
  reg psr_r; // prescaler reset strobe

  // ==========================================================
  // synchronizer stages
  reg [2:0] fck_s_r; // fast clock pin, two stages plus edge stage
  reg [1:0] lock_s_r; // pll lock pin
  reg [1:0] fault_s_r; // fault pin
  reg [31:0] ctl_s1_r; // control bits, first stage
  reg [31:0] ctl_s2_r; // control bits, second stage
  reg [9:0] buf_s1_r [0:3]; // compare buffers, first stage
  reg [9:0] buf_s2_r [0:3]; // compare buffers, second stage
  reg [1:0] cwr_s_r; // count write strobe stages
  reg [9:0] cwd_s1_r; // count write data stages
  reg [9:0] cwd_s2_r;
  reg [1:0] psr_s_r; // prescaler reset stages
  reg [9:0] cnt_s1_r; // count back to bus, two stages
  reg [9:0] cnt_s2_r;
  reg [4:0] ev_s1_r; // flag events back to bus, two stages
  reg [4:0] ev_s2_r;

  // ==========================================================
  // counter side registers
  reg [9:0] count_value_r; // the counter
  reg down_r; // counting down in up/down mode
  reg block_r; // blocks matches for one tick after a count write
  reg half_r; // halves the fast clock in low speed mode
  reg [9:0] act_r [0:3]; // active compare values
  reg [4:0] ev_r; // flag events raised this cycle

  // ==========================================================
  // decoded control, counter domain
  wire [2:0] pwm_en = ctl_s2_r[2:0];
  wire [3:0] clock_select = ctl_s2_r[11:8];
  wire [5:0] compare_output_mode = ctl_s2_r[21:16];
  wire [1:0] waveform_mode = ctl_s2_r[25:24];
  wire fast_clock_enable = ctl_s2_r[26];
  wire low_speed_select = ctl_s2_r[27];
  wire pwm_any = |pwm_en;
  wire updown = pwm_any & (waveform_mode == `HSTC_WM_UPDN);
  wire [9:0] top_value = (waveform_mode == `HSTC_WM_MAX) ? `HSTC_MAX : act_r[2];
  wire at_top = (count_value_r == top_value);
  wire at_bottom = (count_value_r == `HSTC_BOTTOM);
  wire fck_rise = fck_s_r[1] & ~fck_s_r[2];
  wire base_tick;
  wire tick;
  wire reload = pwm_any & tick & (updown ? at_bottom : at_top);

  // fast clock edges in async mode, every hclk otherwise
  assign base_tick = fast_clock_enable ? (fck_rise & (~low_speed_select | half_r)) : 1'b1;

  hstc_prescaler u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .base_tick(base_tick),
    .clr(psr_s_r[1]),
    .clock_select(clock_select),
    .tick(tick)
  );

  // ==========================================================
  // ahb decode: writes take one wait state so a following read sees them, except count, which returns through the crossing stages
  wire acc = hsel & hready & htrans[1] & ce;
  wire [5:0] rd_addr = haddr[5:0];
  wire cmp_sel_rd = (rd_addr == `HSTC_OFS_CMP_A) | (rd_addr == `HSTC_OFS_CMP_B) |
                    (rd_addr == `HSTC_OFS_TOP) | (rd_addr == `HSTC_OFS_CMP_D);

  assign hreadyout = ce & ~wr_pend_r;
  assign hresp = 1'b0;

  // compare channel index from an offset
  function [1:0] cmp_idx;
    input [5:0] ofs;
    begin
      cmp_idx = ofs[4] ? 2'h3 : (ofs[3:2] - 2'h1);
    end
  endfunction

  // true for the four compare offsets
  function is_cmp;
    input [5:0] ofs;
    begin
      is_cmp = (ofs == `HSTC_OFS_CMP_A) | (ofs == `HSTC_OFS_CMP_B) |
               (ofs == `HSTC_OFS_TOP) | (ofs == `HSTC_OFS_CMP_D);
    end
  endfunction

  // read mux, unmapped offsets read zero
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (rd_addr)
      `HSTC_OFS_COUNT: rd_mux[7:0] = cnt_s2_r[7:0];
      `HSTC_OFS_HIGH: rd_mux[1:0] = shared_high_bits_r;
      `HSTC_OFS_CTRL_A: rd_mux[7:0] = control_a_r;
      `HSTC_OFS_CTRL_B: rd_mux[7:0] = control_b_r;
      `HSTC_OFS_CTRL_C: rd_mux[7:0] = control_c_r;
      `HSTC_OFS_CTRL_D: rd_mux[7:0] = {control_d_r[7], interrupt_flags_r[`HSTC_F_FAULT], control_d_r[5:0]};
      `HSTC_OFS_FLAGS: rd_mux[4:0] = interrupt_flags_r;
      `HSTC_OFS_MASK: rd_mux[7:0] = interrupt_mask_r;
      `HSTC_OFS_PLL: rd_mux[7:0] = {pll_control_status_r[7:1], lock_s_r[1]};
      default: begin
        if (cmp_sel_rd) begin
          rd_mux[7:0] = buf_r[cmp_idx(rd_addr)][7:0];
        end
      end
    endcase
  end

  // ==========================================================
  // bus side state: register writes, read side effects, flags
  wire wr_now = wr_pend_r;
  wire [9:0] wr_word = {shared_high_bits_r, hwdata[7:0]};
  wire [4:0] flag_clr = int_ack | ((wr_now && wr_addr_r == `HSTC_OFS_FLAGS) ? hwdata[4:0] : 5'h00) |
                        ((wr_now && wr_addr_r == `HSTC_OFS_CTRL_D && hwdata[`HSTC_B_FAULT]) ? 5'h10 : 5'h00);
  integer k;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 6'h00;
      hrdata <= 32'h0000_0000;
      shared_high_bits_r <= 2'h0;
      control_a_r <= `HSTC_RST_CTRL;
      control_b_r <= `HSTC_RST_CTRL;
      control_c_r <= `HSTC_RST_CTRL;
      control_d_r <= `HSTC_RST_CTRL;
      interrupt_mask_r <= `HSTC_RST_CTRL;
      pll_control_status_r <= `HSTC_RST_CTRL;
      interrupt_flags_r <= 5'h00;
      cnt_wr_r <= 1'b0;
      cnt_wdat_r <= 10'h000;
      psr_r <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        buf_r[k] <= (k == 2) ? `HSTC_RST_TOP : `HSTC_RST_CMP;
      end
    end else if (ce) begin
      wr_pend_r <= acc & hwrite & ~wr_pend_r;
      cnt_wr_r <= 1'b0;
      psr_r <= 1'b0;
      if (acc) begin
        wr_addr_r <= rd_addr;
      end
      // read address phase: answer and copy upper bits to the buffer
      if (acc && !hwrite) begin
        hrdata <= rd_mux;
        if (rd_addr == `HSTC_OFS_COUNT) begin
          shared_high_bits_r <= cnt_s2_r[9:8];
        end else if (cmp_sel_rd) begin
          shared_high_bits_r <= buf_r[cmp_idx(rd_addr)][9:8];
        end
      end
      // write data phase
      if (wr_now) begin
        case (wr_addr_r)
          `HSTC_OFS_COUNT: begin
            cnt_wr_r <= 1'b1;
            cnt_wdat_r <= wr_word;
          end
          `HSTC_OFS_HIGH: shared_high_bits_r <= hwdata[1:0];
          `HSTC_OFS_CTRL_A: control_a_r <= hwdata[7:0];
          `HSTC_OFS_CTRL_B: begin
            control_b_r <= {1'b0, 1'b0, hwdata[5:0]};
            psr_r <= hwdata[`HSTC_B_PSR];
          end
          `HSTC_OFS_CTRL_C: control_c_r <= hwdata[7:0];
          `HSTC_OFS_CTRL_D: control_d_r <= {hwdata[7], 1'b0, hwdata[5:0]};
          `HSTC_OFS_MASK: interrupt_mask_r <= hwdata[7:0];
          `HSTC_OFS_PLL: pll_control_status_r <= {hwdata[7:1], 1'b0};
          default: begin
            if (is_cmp(wr_addr_r)) begin
              buf_r[cmp_idx(wr_addr_r)] <= wr_word;
            end
          end
        endcase
      end
      // an arriving event wins over a clear in the same cycle
      interrupt_flags_r <= (interrupt_flags_r & ~flag_clr) | ev_s2_r;
    end
  end

  // each source gated by its own enable
  assign int_req = interrupt_flags_r & {control_d_r[`HSTC_B_FIE], interrupt_mask_r[3:0]};

  // ==========================================================
  // crossing stages; two flops each way keep the delays of the async part
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fck_s_r <= 3'h0;
      lock_s_r <= 2'h0;
      fault_s_r <= 2'h0;
      ctl_s1_r <= 32'h0000_0000;
      ctl_s2_r <= 32'h0000_0000;
      cwr_s_r <= 2'h0;
      cwd_s1_r <= 10'h000;
      cwd_s2_r <= 10'h000;
      psr_s_r <= 2'h0;
      cnt_s1_r <= 10'h000;
      cnt_s2_r <= 10'h000;
      ev_s1_r <= 5'h00;
      ev_s2_r <= 5'h00;
    end else if (ce) begin
      fck_s_r <= {fck_s_r[1:0], fast_clock_pin};
      lock_s_r <= {lock_s_r[0], pll_lock_pin};
      fault_s_r <= {fault_s_r[0], fault_pin};
      ctl_s1_r <= {4'h0, pll_control_status_r[`HSTC_B_LSM], pll_control_status_r[`HSTC_B_FCKE],
                   control_d_r[1:0], 2'h0, control_c_r[5:0], 4'h0, control_b_r[3:0],
                   5'h00, control_a_r[2:0]};
      ctl_s2_r <= ctl_s1_r;
      cwr_s_r <= {cwr_s_r[0], cnt_wr_r};
      cwd_s1_r <= cnt_wdat_r;
      cwd_s2_r <= cwd_s1_r;
      psr_s_r <= {psr_s_r[0], psr_r};
      cnt_s1_r <= count_value_r;
      cnt_s2_r <= cnt_s1_r;
      ev_s1_r <= ev_r;
      ev_s2_r <= ev_s1_r;
    end
  end

  // ==========================================================
  // counter unit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_value_r <= `HSTC_BOTTOM;
      down_r <= 1'b0;
      block_r <= 1'b0;
      half_r <= 1'b0;
    end else if (ce) begin
      if (fck_rise) begin
        half_r <= ~half_r;
      end
      if (cwr_s_r[1]) begin
        count_value_r <= cwd_s2_r;
        block_r <= 1'b1;
      end else if (tick) begin
        block_r <= 1'b0;
        if (updown) begin
          if (!down_r) begin
            down_r <= at_top;
            count_value_r <= at_top ? count_value_r - 10'h001 : count_value_r + 10'h001;
          end else begin
            down_r <= ~at_bottom;
            count_value_r <= at_bottom ? count_value_r + 10'h001 : count_value_r - 10'h001;
          end
        end else begin
          down_r <= 1'b0;
          count_value_r <= at_top ? `HSTC_BOTTOM : count_value_r + 10'h001;
        end
      end
    end
  end

  // ==========================================================
  // compare channels a, b, top, d
  wire [3:0] match;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_cmp
      // crossing stages and active value
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          buf_s1_r[g] <= (g == 2) ? `HSTC_RST_TOP : `HSTC_RST_CMP;
          buf_s2_r[g] <= (g == 2) ? `HSTC_RST_TOP : `HSTC_RST_CMP;
          act_r[g] <= (g == 2) ? `HSTC_RST_TOP : `HSTC_RST_CMP;
        end else if (ce) begin
          buf_s1_r[g] <= buf_r[g];
          buf_s2_r[g] <= buf_s1_r[g];
          // pwm reloads at top or bottom only, avoiding odd pulses
          if (!pwm_any || reload) begin
            act_r[g] <= buf_s2_r[g];
          end
        end
      end
      // a count write keeps the next tick from matching
      assign match[g] = tick & ~block_r & (count_value_r == act_r[g]);
    end
  endgenerate

  // compare and overflow events registered one hclk cycle after the tick that found equality; fault follows the synchronized pin
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_r <= 5'h00;
    end else if (ce) begin
      ev_r[`HSTC_F_OVF] <= tick & ~cwr_s_r[1] & (updown ? (down_r & at_bottom) : at_top);
      ev_r[`HSTC_F_A] <= match[0] & ~cwr_s_r[1];
      ev_r[`HSTC_F_B] <= match[1] & ~cwr_s_r[1];
      ev_r[`HSTC_F_D] <= match[3] & ~cwr_s_r[1];
      ev_r[`HSTC_F_FAULT] <= fault_s_r[1];
    end
  end

  // ==========================================================
  // waveform outputs; mode 01 toggles, 10 clears, 11 sets on match,
  // pwm sets at bottom and clears on match for any nonzero mode
  function wave;
    input cur;
    input pwm;
    input [1:0] com;
    input hit;
    input bot;
    begin
      wave = cur;
      if (com != 2'h0) begin
        if (pwm) begin
          if (hit) begin
            wave = 1'b0;
          end else if (bot) begin
            wave = 1'b1;
          end
        end else if (hit) begin
          wave = (com == 2'h1) ? ~cur : com[0];
        end
      end
    end
  endfunction

  wire bot_tick = tick & at_bottom;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_pin_a <= 1'b0;
      compare_pin_b <= 1'b0;
      compare_pin_d <= 1'b0;
    end else if (ce) begin
      compare_pin_a <= wave(compare_pin_a, pwm_en[0], compare_output_mode[1:0], match[0], bot_tick);
      compare_pin_b <= wave(compare_pin_b, pwm_en[1], compare_output_mode[3:2], match[1], bot_tick);
      compare_pin_d <= wave(compare_pin_d, pwm_en[2], compare_output_mode[5:4], match[3], bot_tick);
    end
  end

endmodule // hstc_core

`default_nettype wire

/* hdl/hstc_regs.vh */
/*
  register map, field positions, reset values and mode codes of the
  high speed timer/counter core.
  assumes a 32-bit AHB-Lite slave port, one aligned word per register.
*/
`ifndef HSTC_REGS_VH
`define HSTC_REGS_VH

// ==========================================================
// register byte offsets
`define HSTC_OFS_COUNT 6'h00
`define HSTC_OFS_CMP_A 6'h04
`define HSTC_OFS_CMP_B 6'h08
`define HSTC_OFS_TOP 6'h0C
`define HSTC_OFS_CMP_D 6'h10
`define HSTC_OFS_HIGH 6'h14
`define HSTC_OFS_CTRL_A 6'h18
`define HSTC_OFS_CTRL_B 6'h1C
`define HSTC_OFS_CTRL_C 6'h20
`define HSTC_OFS_CTRL_D 6'h24
`define HSTC_OFS_FLAGS 6'h28
`define HSTC_OFS_MASK 6'h2C
`define HSTC_OFS_PLL 6'h30

// ==========================================================
// field positions
`define HSTC_B_PSR 6
`define HSTC_B_FAULT 6
`define HSTC_B_FIE 7
`define HSTC_B_LOCK 0
`define HSTC_B_FCKE 2
`define HSTC_B_LSM 7
`define HSTC_F_OVF 0
`define HSTC_F_A 1
`define HSTC_F_B 2
`define HSTC_F_D 3
`define HSTC_F_FAULT 4

// ==========================================================
// reset values and count limits
`define HSTC_RST_CMP 10'h000
`define HSTC_RST_TOP 10'h0FF
`define HSTC_RST_CTRL 8'h00
`define HSTC_MAX 10'h0FF
`define HSTC_BOTTOM 10'h000

// ==========================================================
// waveform mode codes
`define HSTC_WM_UP 2'h0
`define HSTC_WM_UPDN 2'h1
`define HSTC_WM_MAX 2'h2

`endif

/* hdl/hstc_prescaler.v */
/*
  prescaler of the timer: divides a base tick by 1 .. 16384 or stops.
  assumes base_tick is a one-cycle pulse on hclk and clr a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module hstc_prescaler (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // control
  input wire base_tick,
  input wire clr,
  input wire [3:0] clock_select,
  // timer tick
  output wire tick
);

  // ==========================================================
  // divider chain
  reg [13:0] div_r; // free running base tick counter
  wire [13:0] div_mask;

  // bits of the divider that must all be one for a tick
  function [13:0] sel_mask;
    input [3:0] cs;
    begin
      sel_mask = (cs == 4'h0) ? 14'h0000 : ((14'h0001 << (cs - 4'h1)) - 14'h0001);
    end
  endfunction

  assign div_mask = sel_mask(clock_select);

  // counter advances on base ticks, clears on software request
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 14'h0000;
    end else if (ce) begin
      if (clr) begin
        div_r <= 14'h0000;
      end else if (base_tick) begin
        div_r <= div_r + 14'h0001;
      end
    end
  end

  // select 0 stops the timer, 1 passes every base tick, n divides by 2^(n-1);
  // no tick in the clearing cycle, so restart latency is independent of phase
  assign tick = base_tick & ~clr & (clock_select != 4'h0) & ((div_r & div_mask) == div_mask);

endmodule // hstc_prescaler

`default_nettype wire

/* testbench/hstc_core_asserts.sv */
/*
  concurrent checks on the ports of hstc_core, bound into every instance.
  assumes one clock hclk, reset hresetn active low, one bus master.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// port checker
module hstc_core_asserts (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // pins and interrupts
  input wire pll_lock_pin,
  input wire [4:0] int_ack,
  input wire [4:0] int_req,
  input wire fault_pin,
  input wire compare_pin_a,
  input wire compare_pin_b,
  input wire compare_pin_d
);
  default clocking dcb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take = hsel && hready && htrans[1] && ce; // accepted address phase
  wire wr_take = take && hwrite;
  wire rd_take = take && !hwrite;
  wire [5:0] ofs = haddr[5:0];
  reg pend_r; // a write data phase is running
  reg [5:0] pofs_r;
  reg [5:0] lofs_r; // offset of the last stored write
  reg [7:0] ldat_r; // byte of the last stored write
  reg lvld_r;
  reg [2:0] fq_r; // cycles the fault pin stayed low, saturating
  // shadow of the last write, stored at the same edge as the slave stores it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      pofs_r <= 6'h00;
      lofs_r <= 6'h00;
      ldat_r <= 8'h00;
      lvld_r <= 1'b0;
      fq_r <= 3'h0;
    end else if (ce) begin
      pend_r <= wr_take;
      if (wr_take) pofs_r <= ofs;
      if (pend_r) begin
        lofs_r <= pofs_r;
        ldat_r <= hwdata[7:0];
        lvld_r <= 1'b1;
      end
      // the synchronizer needs a quiet pin for a while before a clear can stick
      fq_r <= fault_pin ? 3'h0 : (fq_r == 3'h7) ? 3'h7 : fq_r + 3'h1;
    end
  end

  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  chk_byte_lane: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data above the byte lane");
  chk_wr_wait: assert property (wr_take |=> !hreadyout ##1 (hreadyout || !ce))
    else $error("write data phase not one wait state");
  chk_rd_nowait: assert property (rd_take |=> hreadyout == ce)
    else $error("read inserted a wait state");
  chk_freeze_ready: assert property (!ce |-> !hreadyout)
    else $error("ready while clock enable low");
  chk_cmp_readback: assert property (rd_take && lvld_r && ofs == lofs_r && ofs >= 6'h04 && ofs <= 6'h10
    |=> hrdata[7:0] == $past(ldat_r))
    else $error("compare read back differs from last write");
  chk_unmapped_zero: assert property (rd_take && ofs > 6'h30 |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  chk_lock_sync: assert property (rd_take && ofs == 6'h30 && $stable(pll_lock_pin)
    && pll_lock_pin == $past(pll_lock_pin, 2) && pll_lock_pin == $past(pll_lock_pin, 3)
    |=> hrdata[0] == $past(pll_lock_pin))
    else $error("lock bit read wrong");
  chk_ack_clear: assert property (int_ack[4] && ce && fq_r == 3'h7 |=> !int_req[4])
    else $error("fault request survived acknowledge");
  chk_reset_quiet: assert property ($rose(hresetn) |-> int_req == 5'h00
    && !compare_pin_a && !compare_pin_b && !compare_pin_d)
    else $error("outputs not quiet after reset");

  // main scenarios reached
  cov_write: cover property (wr_take);
  cov_cmp_read: cover property (rd_take && ofs >= 6'h04 && ofs <= 6'h10);
  cov_ack: cover property (int_ack != 5'h00);
  cov_fault_req: cover property (int_req[4]);
endmodule // hstc_core_asserts

bind hstc_core hstc_core_asserts u_chk (.*);
`default_nettype wire

/* testbench/hstc_env_model.sv */
/*
  model of the surroundings: pll clock and lock, interrupt acknowledge.
  assumes hclk at 4 ns; the pll is taken as enabled from reset.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// environment model
module hstc_env_model #(
  parameter int FAST_HALF_NS = 12,
  parameter int LOCK_CYC = 200
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // interrupt side
  input wire logic [1:0] ack_dly,
  input wire logic [4:0] int_req,
  output logic [4:0] int_ack,
  // pll side
  output logic fast_clock_pin,
  output logic pll_lock_pin
);
  logic [1:0] wait_r; // cycles a request has waited
  int lock_r; // cycles since reset, stands in for pll settling
  // free running pll clock, slower than half of hclk so every edge is seen
  initial fast_clock_pin = 1'b0;
  always #(FAST_HALF_NS) fast_clock_pin = ~fast_clock_pin;
  // acknowledge after ack_dly cycles, one pulse per request
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_ack <= 5'h00;
      wait_r <= 2'h0;
      lock_r <= 0;
      pll_lock_pin <= 1'b0;
    end else begin
      wait_r <= (int_req == 5'h00) ? 2'h0 : (wait_r == ack_dly) ? wait_r : wait_r + 2'h1;
      int_ack <= (wait_r == ack_dly) ? (int_req & ~int_ack) : 5'h00;
      if (lock_r < LOCK_CYC) lock_r <= lock_r + 1;
      pll_lock_pin <= (lock_r >= LOCK_CYC);
    end
  end
endmodule // hstc_env_model
`default_nettype wire

/* testbench/hstc_core_tb_top.sv */
/*
  self-checking bench of hstc_core over AHB-Lite with the environment model.
  assumes the register map of hstc_regs.vh and one slave on the bus.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hstc_regs.vh"

// ==========================================================
// bench top
module hstc_core_tb_top;
  localparam int FAST_CYC = 6; // hclk cycles per pll clock
  logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0, fault_pin = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [1:0] htrans = 2'h0, ack_dly = 2'h0;
  wire hreadyout, hresp, fast_clock_pin, pll_lock_pin, compare_pin_a, compare_pin_b, compare_pin_d;
  wire [31:0] hrdata;
  wire [4:0] int_ack, int_req;
  integer n_fail = 0, num_checks = 0, cyc = 0, seed = 32'h6c3bea59, i, p1, p2, lat[2];
  logic [5:0] ofs_t [6] = '{`HSTC_OFS_CMP_A, `HSTC_OFS_CMP_B, `HSTC_OFS_TOP, `HSTC_OFS_CMP_D,
    `HSTC_OFS_CTRL_A, `HSTC_OFS_CTRL_C};
  logic [7:0] msk_t [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h3F};
  int cs_t [7] = '{1, 2, 4, 1, 1, 1, 1}, wm_t [7] = '{0, 0, 3, 2, 1, 0, 0}, pwm_t [7] = '{0, 0, 0, 0, 3, 0, 0};
  logic [7:0] pll_t [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h84};

  hstc_core dut (.*, .hsize(3'h2), .hready(hreadyout));
  hstc_env_model env (.*);

  always #2 hclk = ~hclk;
  // watchdog: the whole run needs well under this many cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end

  task automatic close_out;
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_fail = n_fail + 1;
    end
  endtask
  // settled ready is looked at mid-cycle, the edge after it is the sampling one
  task automatic wait_rdy;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
  endtask
  // one single transfer, entered just after a rising edge; read data lands in q
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {26'h0, a};
    hwrite <= w;
    wait_rdy;
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy;
    q = hrdata;
    @(posedge hclk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a);
    xfer(1'b0, a, 8'h00);
  endtask
  // cycles up to the first request rise (nskip 0) or between rises nskip and nskip+1
  task automatic edge_cnt(input int b, input int nskip, output int p);
    int k;
    logic prev;
    k = 0;
    p = 0;
    prev = 1'b1;
    while (k <= nskip) begin
      @(negedge hclk);
      p = p + 1;
      if (int_req[b] === 1'b1 && prev !== 1'b1) begin
        k = k + 1;
        if (k <= nskip) p = 0;
      end
      prev = int_req[b];
    end
    @(posedge hclk);
  endtask
  // request period in hclk cycles for a mode, divider and base clock
  function automatic int exp_per(int cs, int top, int wm, int pwm, int fck);
    int base;
    base = (wm == 2) ? 256 : (wm == 1 && pwm != 0) ? 2 * top : top + 1;
    return (base << (cs - 1)) * fck;
  endfunction
  task automatic run_mode(input int cs, input int wm, input int pwm, input logic [7:0] pll);
    int top, e;
    top = 8 + ($unsigned($random(seed)) % 33);
    e = exp_per(cs, top, wm, pwm, pll[7] ? 2 * FAST_CYC : pll[2] ? FAST_CYC : 1);
    wr(`HSTC_OFS_CTRL_B, 8'h00);
    wr(`HSTC_OFS_HIGH, 8'h00);
    wr(`HSTC_OFS_TOP, top[7:0]);
    wr(`HSTC_OFS_CMP_A, top[8:1]);
    wr(`HSTC_OFS_CTRL_D, wm[7:0]);
    wr(`HSTC_OFS_CTRL_A, pwm[7:0]);
    wr(`HSTC_OFS_MASK, 8'h03);
    wr(`HSTC_OFS_CTRL_C, 8'h01);
    wr(`HSTC_OFS_PLL, pll);
    wr(`HSTC_OFS_COUNT, 8'h00);
    wr(`HSTC_OFS_CTRL_B, cs[7:0]);
    edge_cnt(0, 2, p1);
    chk(p1, e);
    if (wm != 1) begin
      edge_cnt(1, 2, p2);
      chk(p2, e);
      // pin a toggles once per period, so one period apart it is inverted
      @(negedge hclk);
      p2 = compare_pin_a;
      repeat (e) @(negedge hclk);
      chk(compare_pin_a, !p2[0]);
    end else begin
      // dual slope matches twice a period, so check the buffered read instead
      wr(`HSTC_OFS_CMP_A, 8'h05);
      rd(`HSTC_OFS_CMP_A);
      chk(q, 32'h05);
    end
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 12; i++) begin
      rd(6'(4 * i));
      chk(q, (i == 3) ? 32'hFF : 32'h00);
    end
    wr(6'h34, 8'hA5);
    rd(6'h34);
    chk(q, 32'h00);
    for (i = 0; i < 6; i++) begin
      p1 = $random(seed) & msk_t[i];
      wr(ofs_t[i], p1[7:0]);
      rd(ofs_t[i]);
      chk(q, p1);
    end
    wr(`HSTC_OFS_HIGH, 8'h02);
    wr(`HSTC_OFS_CMP_B, 8'h5A);
    wr(`HSTC_OFS_HIGH, 8'h00);
    rd(`HSTC_OFS_CMP_B);
    chk(q, 32'h5A);
    repeat (8) @(posedge hclk);
    rd(`HSTC_OFS_HIGH);
    chk(q, 32'h02);
    wr(`HSTC_OFS_HIGH, 8'h00);
    wr(`HSTC_OFS_COUNT, 8'h37);
    ce <= 1'b0;
    repeat (3) @(posedge hclk);
    ce <= 1'b1;
    repeat (30) @(posedge hclk);
    rd(`HSTC_OFS_COUNT);
    chk(q, 32'h37);
    for (i = 0; i < 7; i++) begin
      ack_dly <= 2'(2 * (i % 2));
      q = 32'h0;
      // lock must read one before the fast clock is enabled
      while (pll_t[i][2] && q[0] !== 1'b1) rd(`HSTC_OFS_PLL);
      run_mode(cs_t[i], wm_t[i], pwm_t[i], pll_t[i]);
    end
    wr(`HSTC_OFS_PLL, 8'h00);
    wr(`HSTC_OFS_MASK, 8'h01);
    wr(`HSTC_OFS_CTRL_D, 8'h00);
    wr(`HSTC_OFS_CTRL_A, 8'h00);
    wr(`HSTC_OFS_TOP, 8'h08);
    // start latency after a prescaler reset must not depend on the phase
    for (i = 0; i < 2; i++) begin
      wr(`HSTC_OFS_CTRL_B, 8'h00);
      wr(`HSTC_OFS_COUNT, 8'h00);
      wr(`HSTC_OFS_FLAGS, 8'h1F);
      repeat (3 + $unsigned($random(seed)) % 8) @(posedge hclk);
      wr(`HSTC_OFS_CTRL_B, 8'h44);
      edge_cnt(0, 0, lat[i]);
    end
    chk(lat[1], lat[0]);
    wr(`HSTC_OFS_CTRL_B, 8'h00);
    wr(`HSTC_OFS_MASK, 8'h00);
    fault_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    fault_pin <= 1'b0;
    repeat (8) @(posedge hclk);
    chk(int_req[4], 1'b0);
    rd(`HSTC_OFS_FLAGS);
    chk(q[4], 1'b1);
    rd(`HSTC_OFS_CTRL_D);
    chk(q[6], 1'b1);
    wr(`HSTC_OFS_FLAGS, 8'h10);
    repeat (6) @(posedge hclk);
    rd(`HSTC_OFS_FLAGS);
    chk(q[4], 1'b0);
    wr(`HSTC_OFS_CTRL_D, 8'h80);
    fault_pin <= 1'b1;
    edge_cnt(4, 0, p1);
    fault_pin <= 1'b0;
    chk(p1 <= 8, 1'b1);
    repeat (20) @(posedge hclk);
    close_out;
  end
endmodule // hstc_core_tb_top
`default_nettype wire
